// ===== msopg_pkg.sv
// Purpose: Shared constants and types for the start-of-packet indication
//          generator.
// Assumes: Nibble-wide media interface lanes, one nibble per pclk.
// Notes:   The control register sits at word index 0x805a on APB.
//
// How it works
// RQ1: Receive indication only while rx enable set
// RQ2: Both rx enables: assert at delimiter, else data-valid
// RQ3: Indication holds until end of frame
// RQ4: Length check forces indication after eight bytes
// RQ5: No check, no delimiter in eight bytes: none
// RQ6: Transmit indication only while tx enable set
// RQ7: Tx delimiter-timing bit selects delimiter-timed indication
// RQ8: Tx length check bit enables tx preamble check
// RQ9: Bits 15:6 read zero; reset value 0x001b
// RQ10: Tx mirrors rx: delimiter or enable start, hold
package msopg_pkg;

    localparam int ADDR_W = 18;
    // Printed offset is a word index; the byte address is four times it
    localparam logic [ADDR_W-1:0] CTRL_INDEX = 18'h0805a;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 18'h20168;
    localparam logic [15:0] CTRL_RESET = 16'h001b;
    localparam logic [15:0] CTRL_WR_MASK = 16'h003f;
    localparam int RX_EN_BIT = 0;
    localparam int RX_SFD_BIT = 1;
    localparam int RX_CHK_BIT = 2;
    localparam int TX_EN_BIT = 3;
    localparam int TX_SFD_BIT = 4;
    localparam int TX_CHK_BIT = 5;

    localparam logic [3:0] SFD_NIBBLE = 4'hd;
    localparam int PREAMBLE_BYTES = 8;
    localparam int NIBBLES_PER_BYTE = 2;
    localparam logic [4:0] PRE_NIBBLES = 5'h10;

    typedef struct packed {
        logic valid;
        logic [3:0] data;
    } msopg_lane_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_PRE = 4'b0010,
        ST_IND = 4'b0100,
        ST_QUIET = 4'b1000
    } msopg_state_t;

endpackage

// ===== msopg_gen.sv
// Purpose: Start-of-packet indication for receive and transmit lanes,
//          with one APB-visible control register.
// Assumes: Receive lane comes from pins; transmit lane from pclk logic.
// Notes:   Path 0 is receive, path 1 is transmit; same machine for both.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module msopg_gen (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [msopg_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire msopg_pkg::msopg_lane_t rx_lane,
    input wire msopg_pkg::msopg_lane_t tx_lane,
    output logic rx_start_of_packet_indication,
    output logic tx_start_of_packet_indication
);
    import msopg_pkg::*;

    function automatic logic is_sfd(input msopg_lane_t l);
        return l.valid && (l.data == SFD_NIBBLE);
    endfunction

    logic [15:0] ctrl_reg;
    logic [31:0] prdata_reg;
    msopg_lane_t rx_meta_reg;
    msopg_lane_t rx_sync_reg;

    wire addr_hit = (paddr == CTRL_ADDR);
    wire setup_phase = psel && !penable;
    wire wr_access = psel && penable && pwrite && addr_hit;
    wire [15:0] ctrl_next = (pwdata[15:0] & CTRL_WR_MASK);

    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_hit;
    assign prdata = prdata_reg;

    // Reserved bits are never stored, so they always read zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RESET; // RQ9
        end else if (wr_access) begin
            ctrl_reg <= ctrl_next; // RQ9
        end
    end

    // Read data captured in setup so it is stable for the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup_phase) begin
            prdata_reg <= addr_hit ? {16'h0000, ctrl_reg} : 32'h0000_0000;
        end
    end

    // Receive lane crosses in from pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_meta_reg <= '0;
            rx_sync_reg <= '0;
        end else begin
            rx_meta_reg <= rx_lane;
            rx_sync_reg <= rx_meta_reg;
        end
    end

    msopg_lane_t lane [2];
    logic [1:0] en_w;
    logic [1:0] sfd_w;
    logic [1:0] chk_w;
    msopg_state_t st_reg [2];
    logic [4:0] cnt_reg [2];

    assign lane[0] = rx_sync_reg;
    assign lane[1] = tx_lane;
    assign en_w = {ctrl_reg[TX_EN_BIT], ctrl_reg[RX_EN_BIT]}; // RQ1 RQ6
    assign sfd_w = {ctrl_reg[TX_SFD_BIT], ctrl_reg[RX_SFD_BIT]}; // RQ7
    assign chk_w = {ctrl_reg[TX_CHK_BIT], ctrl_reg[RX_CHK_BIT]}; // RQ8

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_path
            msopg_state_t st_next;
            logic [4:0] cnt_next;
            wire last_pre = (cnt_reg[g] == PRE_NIBBLES - 5'h01);

            always_comb begin
                st_next = st_reg[g];
                cnt_next = cnt_reg[g];
                unique case (st_reg[g])
                    ST_IDLE: begin
                        cnt_next = 5'h00;
                        if (lane[g].valid) begin
                            if (!en_w[g]) begin
                                st_next = ST_QUIET; // RQ1 RQ6
                            end else if (!sfd_w[g]) begin
                                st_next = ST_IND; // RQ2 RQ10
                            end else if (is_sfd(lane[g])) begin
                                st_next = ST_IND; // RQ2 RQ10
                            end else begin
                                st_next = ST_PRE;
                                cnt_next = 5'h01;
                            end
                        end
                    end
                    ST_PRE: begin
                        if (!lane[g].valid) begin
                            st_next = ST_IDLE;
                        end else if (!en_w[g]) begin
                            st_next = ST_QUIET;
                        end else if (is_sfd(lane[g])) begin
                            st_next = ST_IND; // RQ2 RQ10
                        end else if (last_pre) begin
                            // Eighth byte done without a delimiter
                            st_next = chk_w[g] ? ST_IND : ST_QUIET; // RQ4 RQ5
                        end else begin
                            cnt_next = cnt_reg[g] + 5'h01;
                        end
                    end
                    ST_IND: begin
                        if (!lane[g].valid) begin
                            st_next = ST_IDLE; // RQ3
                        end else if (!en_w[g]) begin
                            st_next = ST_QUIET; // RQ1 RQ6
                        end
                    end
                    ST_QUIET: begin
                        // Suppressed frames stay quiet until they end
                        if (!lane[g].valid) begin
                            st_next = ST_IDLE;
                        end
                    end
                    default: begin
                        st_next = ST_IDLE;
                    end
                endcase
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    st_reg[g] <= ST_IDLE;
                    cnt_reg[g] <= 5'h00;
                end else begin
                    st_reg[g] <= st_next;
                    cnt_reg[g] <= cnt_next;
                end
            end
        end
    endgenerate

    // Indications come straight from the state flops
    assign rx_start_of_packet_indication = (st_reg[0] == ST_IND); // RQ3
    assign tx_start_of_packet_indication = (st_reg[1] == ST_IND); // RQ10

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_rx_pre_sfd;
        (st_reg[0] == ST_PRE) && is_sfd(lane[0]) && ctrl_reg[RX_EN_BIT];
    endsequence

    sequence s_rx_eight_bytes;
        (st_reg[0] == ST_PRE) && lane[0].valid && !is_sfd(lane[0])
            && (cnt_reg[0] == 5'h0f) && ctrl_reg[RX_EN_BIT];
    endsequence

    sequence s_tx_pre_sfd;
        (st_reg[1] == ST_PRE) && is_sfd(lane[1]) && ctrl_reg[TX_EN_BIT];
    endsequence

    sequence s_tx_eight_bytes;
        (st_reg[1] == ST_PRE) && lane[1].valid && !is_sfd(lane[1])
            && (cnt_reg[1] == 5'h0f) && ctrl_reg[TX_EN_BIT];
    endsequence

    a_rx_enable_gate: assert property ( // RQ1
        !ctrl_reg[RX_EN_BIT] && $stable(ctrl_reg)
            |=> !rx_start_of_packet_indication)
        else $error("rx indication while rx disabled");

    a_rx_sfd_timing: assert property ( // RQ2
        s_rx_pre_sfd |=> rx_start_of_packet_indication)
        else $error("rx indication missed delimiter");

    a_rx_dv_timing: assert property ( // RQ2
        (st_reg[0] == ST_IDLE) && lane[0].valid && ctrl_reg[RX_EN_BIT]
            && !ctrl_reg[RX_SFD_BIT] |=> rx_start_of_packet_indication)
        else $error("rx indication missed data valid");

    a_rx_hold_end: assert property ( // RQ3
        rx_start_of_packet_indication && !lane[0].valid
            |=> !rx_start_of_packet_indication)
        else $error("rx indication outlived frame");

    a_rx_len_check: assert property ( // RQ4
        (s_rx_eight_bytes and ctrl_reg[RX_CHK_BIT])
            |=> rx_start_of_packet_indication)
        else $error("rx length check did not assert");

    a_rx_no_check: assert property ( // RQ5
        (s_rx_eight_bytes and !ctrl_reg[RX_CHK_BIT])
            |=> (st_reg[0] == ST_QUIET) && !rx_start_of_packet_indication)
        else $error("rx asserted without delimiter");

    a_tx_enable_gate: assert property ( // RQ6
        !ctrl_reg[TX_EN_BIT] && $stable(ctrl_reg)
            |=> !tx_start_of_packet_indication)
        else $error("tx indication while tx disabled");

    a_tx_sfd_select: assert property ( // RQ7
        (st_reg[1] == ST_IDLE) && lane[1].valid && !is_sfd(lane[1])
            && ctrl_reg[TX_EN_BIT] && ctrl_reg[TX_SFD_BIT]
            |=> (st_reg[1] == ST_PRE) && !tx_start_of_packet_indication)
        else $error("tx asserted before delimiter");

    a_tx_len_check: assert property ( // RQ8
        (st_reg[1] == ST_PRE) && lane[1].valid && !is_sfd(lane[1])
            && (cnt_reg[1] == 5'h0f) && ctrl_reg[TX_EN_BIT]
            |=> tx_start_of_packet_indication == $past(ctrl_reg[TX_CHK_BIT]))
        else $error("tx length check wrong");

    a_tx_hold_frame: assert property ( // RQ10
        tx_start_of_packet_indication && tx_lane.valid
            && ctrl_reg[TX_EN_BIT] |=> tx_start_of_packet_indication)
        else $error("tx indication dropped mid frame");

    a_reg_reserved: assert property ( // RQ9
        psel && penable && addr_hit && !pwrite |-> prdata[31:6] == 26'h0)
        else $error("reserved bits read nonzero");

    a_reg_write_read: assert property ( // RQ9
        wr_access ##1 (psel && !penable && addr_hit) ##1 (psel && penable)
            |-> prdata[5:0] == $past(pwdata[5:0], 2))
        else $error("control write not read back");

    // Nothing may show up early while still counting preamble
    a_rx_no_early: assert property ( // RQ4
        (st_reg[0] == ST_PRE) && lane[0].valid && !is_sfd(lane[0])
            && (cnt_reg[0] != 5'h0f) && ctrl_reg[RX_EN_BIT]
            |=> !rx_start_of_packet_indication)
        else $error("rx indication before eight bytes");

    a_rx_sfd_select: assert property ( // RQ2
        (st_reg[0] == ST_IDLE) && lane[0].valid && !is_sfd(lane[0])
            && ctrl_reg[RX_EN_BIT] && ctrl_reg[RX_SFD_BIT]
            |=> (st_reg[0] == ST_PRE) && !rx_start_of_packet_indication)
        else $error("rx asserted before delimiter");

    a_rx_hold_frame: assert property ( // RQ3
        rx_start_of_packet_indication && lane[0].valid
            && ctrl_reg[RX_EN_BIT] |=> rx_start_of_packet_indication)
        else $error("rx indication dropped mid frame");

    // A suppressed frame must stay dark even if enables change mid frame
    a_rx_quiet_hold: assert property ( // RQ1 RQ5
        (st_reg[0] == ST_QUIET) && lane[0].valid
            |=> !rx_start_of_packet_indication)
        else $error("rx indication in suppressed frame");

    // Transmit lane has no synchroniser, so its checks are one edge deep
    a_tx_sfd_timing: assert property ( // RQ10
        s_tx_pre_sfd |=> tx_start_of_packet_indication)
        else $error("tx indication missed delimiter");

    a_tx_dv_timing: assert property ( // RQ7 RQ10
        (st_reg[1] == ST_IDLE) && lane[1].valid && ctrl_reg[TX_EN_BIT]
            && !ctrl_reg[TX_SFD_BIT] |=> tx_start_of_packet_indication)
        else $error("tx indication missed enable");

    a_tx_hold_end: assert property ( // RQ10
        tx_start_of_packet_indication && !lane[1].valid
            |=> !tx_start_of_packet_indication)
        else $error("tx indication outlived frame");

    a_tx_no_early: assert property ( // RQ8
        (st_reg[1] == ST_PRE) && lane[1].valid && !is_sfd(lane[1])
            && (cnt_reg[1] != 5'h0f) && ctrl_reg[TX_EN_BIT]
            |=> !tx_start_of_packet_indication)
        else $error("tx indication before eight bytes");

    a_tx_no_check: assert property ( // RQ8
        (s_tx_eight_bytes and !ctrl_reg[TX_CHK_BIT])
            |=> (st_reg[1] == ST_QUIET) && !tx_start_of_packet_indication)
        else $error("tx asserted without delimiter");

    a_tx_quiet_hold: assert property ( // RQ6
        (st_reg[1] == ST_QUIET) && lane[1].valid
            |=> !tx_start_of_packet_indication)
        else $error("tx indication in suppressed frame");

    a_reg_write_store: assert property ( // RQ9
        wr_access |=> (ctrl_reg[5:0] == $past(pwdata[5:0]))
            && (ctrl_reg[15:6] == 10'h000))
        else $error("control write not stored");

    // Refused transfers must leave the settings untouched
    a_reg_unmapped_keep: assert property ( // RQ9
        psel && penable && !addr_hit |=> $stable(ctrl_reg))
        else $error("unmapped write changed control");

endmodule

// ===== msopg_mac_model.sv
// Purpose: Far-side consumer that counts cycles of each indication.
// Assumes: Indications are active-high levels in the pclk domain.
// Notes:   The bench clears the counts before each frame.
`timescale 1ns/1ps
module msopg_mac_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clr,
    input wire logic rx_ind,
    input wire logic tx_ind,
    output logic [15:0] rx_cnt,
    output logic [15:0] tx_cnt
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_cnt <= 16'h0;
            tx_cnt <= 16'h0;
        end else if (clr) begin
            rx_cnt <= 16'h0;
            tx_cnt <= 16'h0;
        end else begin
            rx_cnt <= rx_cnt + {15'h0, rx_ind};
            tx_cnt <= tx_cnt + {15'h0, tx_ind};
        end
    end
endmodule

// ===== tb_mac_sop_indication_gen.sv
// Purpose: Self-checking bench for the start-of-packet generator.
// Assumes: Zero-wait APB slave; one nibble per clock on both lanes.
// Notes:   Counting high cycles checks both the start point and the hold.
`timescale 1ns/1ps
module tb_mac_sop_indication_gen;
import msopg_pkg::*;
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
n_mismatch++; $display("wrong value %s exp %h got %h", nm, e, g); end end
logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
logic pwrite = 1'b0, clr = 1'b0, pready, pslverr, err, rx_ind, tx_ind;
logic [ADDR_W-1:0] paddr = '0;
logic [31:0] pwdata = '0, prdata, rd;
msopg_lane_t rx_lane = '0, tx_lane = '0;
logic [15:0] rx_cnt, tx_cnt;
int n_mismatch = 0, n_compared = 0, cycles = 0;
logic [31:0] cw[8] = '{32'h1b, 32'h1b, 32'h1b, 32'h3f, 32'h3f, 32'h36,
    32'h09, 32'hffff_ffff};
int cl[8] = '{20, 20, 20, 20, 10, 20, 20, 24};
int cp[8] = '{0, 15, 16, 16, -1, 5, -1, -1};
always #20 pclk = ~pclk;
msopg_gen msopg_gen_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_lane(rx_lane), .tx_lane(tx_lane),
    .rx_start_of_packet_indication(rx_ind),
    .tx_start_of_packet_indication(tx_ind));
msopg_mac_model msopg_mac_model_i (.pclk(pclk), .presetn(presetn),
    .clr(clr), .rx_ind(rx_ind), .tx_ind(tx_ind), .rx_cnt(rx_cnt),
    .tx_cnt(tx_cnt));
task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
endtask
always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
        n_mismatch++;
        finish_test();
    end
end
// Expected high cycles for one frame of len nibbles, delimiter at p
function automatic logic [15:0] expc(logic en, logic sfd, logic chk,
    int len, int p);
    if (!en) return 16'h0;
    if (!sfd) return 16'(len);
    if (p >= 0 && p < 16 && p < len) return 16'(len - p);
    if (chk && len > 15) return 16'(len - 15);
    return 16'h0;
endfunction
task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
    input logic [31:0] d, input logic hold);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50) n_mismatch++;
    rd = prdata;
    err = pslverr;
    // Held select lets the next setup follow at once without a glitch
    if (!hold) psel <= 1'b0;
    penable <= 1'b0;
endtask
task automatic run(input logic [31:0] w, input int len, input int p);
    logic [3:0] nb;
    apb(1'b1, CTRL_ADDR, w, 1'b1);
    apb(1'b0, CTRL_ADDR, 32'h0, 1'b0);
    `CHK("ctrl", {26'h0, w[5:0]}, rd)
    `CHK("err", 1'b0, err)
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    for (int i = 0; i < len; i++) begin
        nb = (p < 0 || i < p) ? 4'h5 : (i == p) ? SFD_NIBBLE : 4'($urandom);
        rx_lane <= '{1'b1, nb};
        tx_lane <= '{1'b1, nb};
        @(posedge pclk);
    end
    // Idle data gets a fresh random nibble each gap so a stale nibble cannot pass for a frame
    rx_lane <= '{1'b0, 4'($urandom)};
    tx_lane <= '{1'b0, 4'($urandom)};
    repeat (6) @(posedge pclk);
    `CHK("rx_cnt", expc(w[0], w[1], w[2], len, p), rx_cnt)
    `CHK("tx_cnt", expc(w[3], w[4], w[5], len, p), tx_cnt)
endtask
initial begin
    void'($urandom(51));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, CTRL_ADDR, 32'h0, 1'b1);
    `CHK("reset", {16'h0, CTRL_RESET}, rd)
    apb(1'b1, CTRL_ADDR + 18'h4, 32'h0, 1'b1);
    `CHK("unmapped", 1'b1, err)
    apb(1'b0, CTRL_ADDR, 32'h0, 1'b1);
    `CHK("kept", {16'h0, CTRL_RESET}, rd)
    for (int k = 0; k < 8; k++) run(cw[k], cl[k], cp[k]);
    for (int k = 0; k < 40; k++)
        run($urandom, 2 + int'($urandom % 30), int'($urandom % 24) - 1);
    finish_test();
end
endmodule
